//--- adcs_defs.svh
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// clock and start-up times in their own units
`define ADCS_CLK_HZ 25000000
`define ADCS_POR_MS 10
`define ADCS_OSC_MS 500
`define ADCS_START_NS 200

// sequence lengths in master clock periods
`define ADCS_CONVERSION_REQUEST_CYC 24'h000658
`define ADCS_CONT_CYC 24'h000656
`define ADCS_CAL_CYC 24'h000cae
`define ADCS_WAKE_CYC 24'h000708

// register byte offsets
`define ADCS_REG_STATUS 4'h0
`define ADCS_REG_IRQ_STAT 4'h4
`define ADCS_REG_IRQ_MASK 4'h8
`define ADCS_REG_CTRL 4'hc

// field positions
`define ADCS_IRQ_CONVERSION_REQUEST 0
`define ADCS_IRQ_CAL 1
`define ADCS_IRQ_WAKE 2
`define ADCS_CTRL_EXTCLK 0
`define ADCS_CTRL_SLEEP 1

// reset values
`define ADCS_CTRL_RST 2'h1
`define ADCS_MASK_RST 3'h0

`endif

//--- adcs_pkg.sv
package adcs_pkg;
    typedef enum logic [6:0] {
        ST_POR = 7'h01,
        ST_OSC = 7'h02,
        ST_WAKE = 7'h04,
        ST_IDLE = 7'h08,
        ST_CONVERSION_REQUEST = 7'h10,
        ST_CAL = 7'h20,
        ST_SLEEP = 7'h40
    } adcs_state_e;

    typedef logic [23:0] adcs_cnt_t;

    typedef struct packed {
        adcs_state_e state;
        logic conversion_request_prev;
        logic cal_prev;
        logic cont;
        logic held;
        logic [1:0] chan;
        logic pol;
        logic rdy_n;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [1:0] ctrl;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } adcs_seq_s;

    typedef struct packed {
        adcs_cnt_t cnt;
    } adcs_tmr_s;
endpackage

//--- adcs_tmr_if.sv
interface adcs_tmr_if;
    logic load;
    adcs_pkg::adcs_cnt_t val;
    logic expire;
    modport ctl (output load, output val, input expire);
    modport tmr (input load, input val, output expire);
endinterface

//--- adcs_timer.sv
module adcs_timer #(
    parameter adcs_pkg::adcs_cnt_t RST_VAL = 24'h000001
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // load and expiry
    adcs_tmr_if.tmr t
);
    import adcs_pkg::*;

    adcs_tmr_s tmr_ff;
    adcs_tmr_s nxt_tmr;

    // a load of n raises expire in the n-th cycle after it
    always_comb
    begin
        nxt_tmr = tmr_ff;
        if (t.load)
            nxt_tmr.cnt = t.val;
        else if (tmr_ff.cnt != 24'h000000)
            nxt_tmr.cnt = tmr_ff.cnt - 24'h000001;
    end

    // reset starts the power-on count at once
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            tmr_ff <= '{cnt: RST_VAL};
        else
            tmr_ff <= nxt_tmr;
    end

    assign t.expire = (tmr_ff.cnt == 24'h000001);
endmodule

//--- adcs_sequencer.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`include "adcs_defs.svh"

// Summary of operation
// - a single-shot conversion ends and flags its result 1624 clocks after start
// - with the request held high, back-to-back conversions take 1622 clocks
// - self-calibration runs 3246 clocks from start to finish
// - a request rising edge starts a conversion within 2 clocks plus 200 ns
// - request and calibrate both high start calibration within 2 clocks plus 200 ns
// - a calibrate pulse while the request is held high also starts calibration
// - power-on reset of about 10 ms after power-up and after leaving sleep
// - a 1800-clock wake-up follows oscillator start or the reset time
// - sleep level powers down; resuming needs reset, oscillator start (crystal only, skipped with external clock) and wake-up
module adcs_sequencer #(
    parameter int unsigned POR_CYC = `ADCS_POR_MS * (`ADCS_CLK_HZ / 1000),
    parameter int unsigned OSC_CYC = `ADCS_OSC_MS * (`ADCS_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // converter control pins
    input wire logic conversion_request,
    input wire logic calibration_select,
    input wire logic channel_addr_bit0,
    input wire logic channel_addr_bit1,
    input wire logic polarity_select,
    input wire logic port_mode_sleep_pin,
    output logic result_ready_n,
    output logic [1:0] result_channel,
    output logic result_polarity,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq
);
    import adcs_pkg::*;

    localparam int start_max = 2 + (`ADCS_START_NS * (`ADCS_CLK_HZ / 1000000)) / 1000;

    adcs_seq_s seq_ff;
    adcs_seq_s nxt_seq;
    adcs_tmr_if tmr_bus();
    logic conversion_request_rise;
    logic cal_rise;
    logic sleep_req;
    logic bus_wr;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] rd_mux;

    adcs_timer #(
        .RST_VAL(24'(POR_CYC))
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .t(tmr_bus.tmr)
    );

    // edges of the host pins; pins are already synchronous to clk
    assign conversion_request_rise = conversion_request & ~seq_ff.conversion_request_prev;
    assign cal_rise = calibration_select & ~seq_ff.cal_prev;
    assign sleep_req = port_mode_sleep_pin | seq_ff.ctrl[`ADCS_CTRL_SLEEP];
    // a write takes effect only at the edge that ends the wait
    assign bus_wr = avs_write & ~seq_ff.waitreq;

    // register read mux, unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (avs_address)
            `ADCS_REG_STATUS:
                rd_mux = {21'h000000, seq_ff.pol, seq_ff.chan, seq_ff.rdy_n, seq_ff.state};
            `ADCS_REG_IRQ_STAT:
                rd_mux = {29'h00000000, seq_ff.irq_stat};
            `ADCS_REG_IRQ_MASK:
                rd_mux = {29'h00000000, seq_ff.irq_mask};
            `ADCS_REG_CTRL:
                rd_mux = {30'h00000000, seq_ff.ctrl};
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    // sequencer, bus slave and interrupt next state
    always_comb
    begin
        nxt_seq = seq_ff;
        tmr_bus.load = 1'b0;
        tmr_bus.val = 24'h000000;
        ev = 3'h0;
        clr = 3'h0;
        nxt_seq.conversion_request_prev = conversion_request;
        nxt_seq.cal_prev = calibration_select;
        unique case (seq_ff.state)
            ST_POR:
                if (tmr_bus.expire)
                begin
                    if (seq_ff.ctrl[`ADCS_CTRL_EXTCLK])
                    begin
                        // external clock: wake-up starts when reset time ends
                        nxt_seq.state = ST_WAKE;
                        tmr_bus.load = 1'b1;
                        tmr_bus.val = `ADCS_WAKE_CYC;
                    end
                    else
                    begin
                        nxt_seq.state = ST_OSC;
                        tmr_bus.load = 1'b1;
                        tmr_bus.val = 24'(OSC_CYC);
                    end
                end
            ST_OSC:
                if (tmr_bus.expire)
                begin
                    // crystal: wake-up starts once the oscillator runs
                    nxt_seq.state = ST_WAKE;
                    tmr_bus.load = 1'b1;
                    tmr_bus.val = `ADCS_WAKE_CYC;
                end
            ST_WAKE:
                if (tmr_bus.expire)
                begin
                    nxt_seq.state = ST_IDLE;
                    ev[`ADCS_IRQ_WAKE] = 1'b1;
                end
            ST_IDLE:
                if (conversion_request && calibration_select && (conversion_request_rise || cal_rise))
                begin
                    nxt_seq.state = ST_CAL;
                    tmr_bus.load = 1'b1;
                    tmr_bus.val = `ADCS_CAL_CYC;
                end
                else if (conversion_request_rise)
                begin
                    // start at the same edge that sees the rise, well inside the window
                    nxt_seq.state = ST_CONVERSION_REQUEST;
                    tmr_bus.load = 1'b1;
                    tmr_bus.val = `ADCS_CONVERSION_REQUEST_CYC;
                    nxt_seq.chan = {channel_addr_bit1, channel_addr_bit0};
                    nxt_seq.cont = 1'b0;
                    nxt_seq.held = 1'b1;
                    nxt_seq.rdy_n = 1'b1;
                end
            ST_CONVERSION_REQUEST:
            begin
                // any dip of the request ends continuous mode
                if (!conversion_request)
                    nxt_seq.held = 1'b0;
                // the low pulse of continuous mode lasts one cycle
                if (seq_ff.cont)
                    nxt_seq.rdy_n = 1'b1;
                if (conversion_request && cal_rise)
                begin
                    // a calibrate pulse aborts the conversion in progress
                    nxt_seq.state = ST_CAL;
                    tmr_bus.load = 1'b1;
                    tmr_bus.val = `ADCS_CAL_CYC;
                    nxt_seq.rdy_n = 1'b1;
                end
                else if (tmr_bus.expire)
                begin
                    nxt_seq.rdy_n = 1'b0;
                    // host holds polarity steady up to this edge
                    nxt_seq.pol = polarity_select;
                    ev[`ADCS_IRQ_CONVERSION_REQUEST] = 1'b1;
                    if (seq_ff.held && conversion_request)
                    begin
                        // back-to-back conversion on the same channel
                        tmr_bus.load = 1'b1;
                        tmr_bus.val = `ADCS_CONT_CYC;
                        nxt_seq.cont = 1'b1;
                    end
                    else
                        nxt_seq.state = ST_IDLE;
                end
            end
            ST_CAL:
                if (tmr_bus.expire)
                begin
                    nxt_seq.state = ST_IDLE;
                    ev[`ADCS_IRQ_CAL] = 1'b1;
                end
            ST_SLEEP:
                if (!sleep_req)
                begin
                    // leaving sleep reruns the whole start-up
                    nxt_seq.state = ST_POR;
                    tmr_bus.load = 1'b1;
                    tmr_bus.val = 24'(POR_CYC);
                end
            default:
            begin
                nxt_seq.state = ST_POR;
                tmr_bus.load = 1'b1;
                tmr_bus.val = 24'(POR_CYC);
            end
        endcase
        // sleep overrides the next state, ready, continuous flag and timer load, including in a running conversion
        if (sleep_req && seq_ff.state != ST_SLEEP)
        begin
            nxt_seq.state = ST_SLEEP;
            nxt_seq.rdy_n = 1'b1;
            nxt_seq.cont = 1'b0;
            tmr_bus.load = 1'b0;
        end
        // bus slave: one wait cycle, then the answer
        if ((avs_read || avs_write) && seq_ff.waitreq)
        begin
            nxt_seq.waitreq = 1'b0;
            nxt_seq.rdata = rd_mux;
        end
        else
            nxt_seq.waitreq = 1'b1;
        if (bus_wr && avs_byteenable[0])
        begin
            unique case (avs_address)
                `ADCS_REG_IRQ_STAT:
                    clr = avs_writedata[2:0];
                `ADCS_REG_IRQ_MASK:
                    nxt_seq.irq_mask = avs_writedata[2:0];
                `ADCS_REG_CTRL:
                    nxt_seq.ctrl = avs_writedata[1:0];
                default:
                    clr = 3'h0;
            endcase
        end
        // a new event beats a clear in the same cycle
        nxt_seq.irq_stat = (seq_ff.irq_stat & ~clr) | ev;
        nxt_seq.irq = |(nxt_seq.irq_stat & nxt_seq.irq_mask);
    end

    // single state register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            seq_ff <= '{state: ST_POR, conversion_request_prev: 1'b0, cal_prev: 1'b0, cont: 1'b0,
                held: 1'b0, chan: 2'h0, pol: 1'b0, rdy_n: 1'b1, irq_stat: 3'h0,
                irq_mask: `ADCS_MASK_RST, ctrl: `ADCS_CTRL_RST, irq: 1'b0,
                waitreq: 1'b1, rdata: 32'h00000000};
        end
        else
            seq_ff <= nxt_seq;
    end

    assign result_ready_n = seq_ff.rdy_n;
    assign result_channel = seq_ff.chan;
    assign result_polarity = seq_ff.pol;
    assign avs_readdata = seq_ff.rdata;
    assign avs_waitrequest = seq_ff.waitreq;
    assign irq = seq_ff.irq;

    // helper: cycles since the last timer load
    logic [23:0] run_ff;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            run_ff <= 24'h000001;
        else if (tmr_bus.load)
            run_ff <= 24'h000001;
        else
            run_ff <= run_ff + 24'h000001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_conversion_request_len;
        seq_ff.state == ST_CONVERSION_REQUEST && tmr_bus.expire && !seq_ff.cont && !sleep_req
            |-> run_ff == 24'd1624;
    endproperty
    a_conversion_request_len: assert property (p_conversion_request_len) else $error("single conversion length wrong");

    property p_cont_len;
        seq_ff.state == ST_CONVERSION_REQUEST && tmr_bus.expire && seq_ff.cont && !sleep_req
            |-> run_ff == 24'd1622;
    endproperty
    a_cont_len: assert property (p_cont_len) else $error("continuous conversion length wrong");

    property p_cal_len;
        seq_ff.state == ST_CAL && tmr_bus.expire && !sleep_req |-> run_ff == 24'd3246 ##1 seq_ff.state == ST_IDLE;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

    property p_conversion_request_start;
        seq_ff.state == ST_IDLE && conversion_request_rise && !calibration_select && !sleep_req
            |-> ##[1:start_max] seq_ff.state == ST_CONVERSION_REQUEST;
    endproperty
    a_conversion_request_start: assert property (p_conversion_request_start) else $error("conversion start late");

    property p_cal_start;
        seq_ff.state == ST_IDLE && conversion_request_rise && calibration_select && !sleep_req
            |-> ##[1:start_max] seq_ff.state == ST_CAL;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration start late");

    property p_cal_pulse;
        seq_ff.state == ST_CONVERSION_REQUEST && conversion_request && cal_rise && !sleep_req
            |=> seq_ff.state == ST_CAL && seq_ff.rdy_n;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibrate pulse ignored");

    property p_por_len;
        seq_ff.state == ST_POR && tmr_bus.expire && !sleep_req |-> run_ff == 24'(POR_CYC);
    endproperty
    a_por_len: assert property (p_por_len) else $error("power-on reset length wrong");

    property p_wake_len;
        seq_ff.state == ST_WAKE && tmr_bus.expire && !sleep_req
            |-> run_ff == 24'd1800 ##1 seq_ff.state == ST_IDLE && seq_ff.irq_stat[`ADCS_IRQ_WAKE];
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake-up length wrong");

    // entry from the pin, and exit once neither the pin nor the control bit asks for sleep
    property p_sleep;
        (port_mode_sleep_pin |=> seq_ff.state == ST_SLEEP && result_ready_n)
            and (seq_ff.state == ST_SLEEP && !port_mode_sleep_pin && !seq_ff.ctrl[`ADCS_CTRL_SLEEP]
            |=> seq_ff.state == ST_POR);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry or exit wrong");

    property p_chan;
        seq_ff.state == ST_IDLE && conversion_request_rise && !calibration_select && !sleep_req
            |=> result_channel == $past({channel_addr_bit1, channel_addr_bit0})
            ##1 result_channel == $past({channel_addr_bit1, channel_addr_bit0}, 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not latched");

    property p_ready;
        seq_ff.state == ST_CONVERSION_REQUEST && tmr_bus.expire && !cal_rise && !sleep_req
            |=> $fell(result_ready_n) && result_polarity == $past(polarity_select);
    endproperty
    a_ready: assert property (p_ready) else $error("data-ready not asserted");

    c_single: cover property (seq_ff.state == ST_CONVERSION_REQUEST && tmr_bus.expire && !seq_ff.cont);
    c_cont: cover property (seq_ff.state == ST_CONVERSION_REQUEST && tmr_bus.expire && seq_ff.cont);
    c_cal: cover property (seq_ff.state == ST_CAL && tmr_bus.expire);
    c_sleep_exit: cover property (seq_ff.state == ST_SLEEP ##1 seq_ff.state == ST_POR);
endmodule

//--- adcs_host.sv
module adcs_host (
    // clock
    input wire logic clk,
    // control pins toward the converter
    output logic conversion_request,
    output logic calibration_select,
    output logic channel_addr_bit0,
    output logic channel_addr_bit1,
    output logic polarity_select
);
    timeunit 1ns;
    timeprecision 1ns;

    // all pins low before the first edge
    initial
    begin
        conversion_request = 1'b0;
        calibration_select = 1'b0;
        channel_addr_bit0 = 1'b0;
        channel_addr_bit1 = 1'b0;
        polarity_select = 1'b0;
    end

    // address leads the request by one edge and is held three edges past the rise
    task automatic start(input logic [1:0] ch, input logic pol, input logic keep);
        channel_addr_bit0 <= ch[0];
        channel_addr_bit1 <= ch[1];
        polarity_select <= pol;
        @(posedge clk);
        conversion_request <= 1'b1;
        repeat (3) @(posedge clk);
        if (!keep)
            conversion_request <= 1'b0;
        // inverted address afterwards, so a late sample of it shows up
        channel_addr_bit0 <= ~ch[0];
        channel_addr_bit1 <= ~ch[1];
    endtask

    // calibrate pulse of three edges, request raised with it or already high
    task automatic cal(input logic with_req);
        calibration_select <= 1'b1;
        if (with_req)
            conversion_request <= 1'b1;
        repeat (3) @(posedge clk);
        calibration_select <= 1'b0;
    endtask

    task automatic stop();
        conversion_request <= 1'b0;
    endtask
endmodule

//--- tb_adc_conversion_sequencer.sv
`include "adcs_defs.svh"

module tb_adc_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR = 20;
    localparam int OSC = 30;
    localparam int WAKE = 24'(`ADCS_WAKE_CYC);
    // one edge to take, one to see, three already spent inside the host task
    localparam int CONVERSION_REQUEST_LAT = 24'(`ADCS_CONVERSION_REQUEST_CYC) - 1;
    localparam int CAL_LAT = 24'(`ADCS_CAL_CYC) - 1;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sleep_pin = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic req, cal_sel, a0, a1, pol_sel, result_ready_n, result_polarity;
    logic [1:0] result_channel;
    int errors = 0;
    int checks = 0;
    int seed = 32'h2a66;
    int cyc = 0;
    // behavioural register model
    logic [2:0] m_stat = 3'h0;
    logic [2:0] m_mask = `ADCS_MASK_RST;
    logic [1:0] m_ctrl = `ADCS_CTRL_RST;
    logic [31:0] rd;

    initial
    begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    adcs_host host (.clk(clk), .conversion_request(req), .calibration_select(cal_sel),
        .channel_addr_bit0(a0), .channel_addr_bit1(a1), .polarity_select(pol_sel));

    adcs_sequencer #(.POR_CYC(POR), .OSC_CYC(OSC)) dut (.clk(clk), .reset_n(reset_n),
        .conversion_request(req), .calibration_select(cal_sel), .channel_addr_bit0(a0),
        .channel_addr_bit1(a1), .polarity_select(pol_sel), .port_mode_sleep_pin(sleep_pin),
        .result_ready_n(result_ready_n), .result_channel(result_channel),
        .result_polarity(result_polarity), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cyc(input string what, input int exp, input int got);
        checks++;
        if (got != exp)
        begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        errors++;
        $display("[ERR] %s expected completion seen timeout", what);
        tally_and_finish();
    endtask

    function automatic logic [31:0] exp_reg(input logic [3:0] a);
        case (a)
            `ADCS_REG_IRQ_STAT: return {29'h0, m_stat};
            `ADCS_REG_IRQ_MASK: return {29'h0, m_mask};
            `ADCS_REG_CTRL: return {30'h0, m_ctrl};
            default: return 32'h0;
        endcase
    endfunction

    // one access; the request stands until waitrequest is sampled low, an edge passes after release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~w;
        avs_write <= w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
            hang("bus");
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (w && be[0])
        begin
            if (a == `ADCS_REG_IRQ_STAT)
                m_stat = m_stat & ~d[2:0];
            else if (a == `ADCS_REG_IRQ_MASK)
                m_mask = d[2:0];
            else if (a == `ADCS_REG_CTRL)
                m_ctrl = d[1:0];
        end
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hf);
        chk($sformatf("reg %h", a), exp_reg(a), rd);
    endtask

    task automatic state_chk(input logic [6:0] exp);
        bus(1'b0, `ADCS_REG_STATUS, 32'h0, 4'hf);
        chk("state", {25'h0, exp}, {25'h0, rd[6:0]});
    endtask

    // polls until idle, then checks the start-up time since t0
    task automatic wait_idle(input int t0, input int extra);
        int k;
        for (k = 0; k < 1500; k++)
        begin
            bus(1'b0, `ADCS_REG_STATUS, 32'h0, 4'hf);
            if (rd[6:0] === 7'h08)
                break;
        end
        if (k == 1500)
            hang("idle");
        chk("start-up time", 32'h1,
            {31'h0, (cyc - t0 >= POR + extra + WAKE) && (cyc - t0 <= POR + extra + WAKE + 10)});
        m_stat[`ADCS_IRQ_WAKE] = 1'b1;
    endtask

    // counts edges until ready is sampled low (sel 0) or irq high (sel 1)
    task automatic wait_pin(input logic sel, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(sel ? irq === 1'b1 : result_ready_n === 1'b0) && n < 5000);
        if (n >= 5000)
            hang("pin wait");
    endtask

    initial
    begin
        int n;
        logic pol;
        repeat (6) @(posedge clk);
        chk("ready_n in reset", 32'h1, {31'h0, result_ready_n});
        chk("irq in reset", 32'h0, {31'h0, irq});
        reset_n <= 1'b1;
        n = cyc;
        rd_chk(`ADCS_REG_CTRL);
        rd_chk(`ADCS_REG_IRQ_MASK);
        rd_chk(4'h2);
        wait_idle(n, 0);
        rd_chk(`ADCS_REG_IRQ_STAT);
        $display("test start-up done");
        // lane 0 disabled write is dropped, then mask, raise, clear
        bus(1'b1, `ADCS_REG_IRQ_MASK, 32'h4, 4'he);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `ADCS_REG_IRQ_MASK, 32'h4, 4'h1);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, `ADCS_REG_IRQ_STAT, 32'h4, 4'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b1, `ADCS_REG_STATUS, 32'hff, 4'hf);
        state_chk(7'h08);
        rd_chk(`ADCS_REG_IRQ_MASK);
        $display("test interrupts done");
        // every channel code, random polarity, single shot
        for (int i = 0; i < 4; i++)
        begin
            pol = 1'($random(seed));
            host.start(2'(i), pol, 1'b0);
            wait_pin(1'b0, n);
            chk_cyc("conversion time", CONVERSION_REQUEST_LAT, n);
            chk("channel", 32'(i), {30'h0, result_channel});
            chk("polarity", {31'h0, pol}, {31'h0, result_polarity});
            m_stat[`ADCS_IRQ_CONVERSION_REQUEST] = 1'b1;
        end
        rd_chk(`ADCS_REG_IRQ_STAT);
        bus(1'b1, `ADCS_REG_IRQ_STAT, 32'h1, 4'h1);
        $display("test single conversions done");
        // request held high runs back to back
        host.start(2'h1, 1'b1, 1'b1);
        wait_pin(1'b0, n);
        wait_pin(1'b0, n);
        chk_cyc("continuous period", 24'(`ADCS_CONT_CYC), n);
        host.stop();
        wait_pin(1'b0, n);
        bus(1'b1, `ADCS_REG_IRQ_STAT, 32'h1, 4'h1);
        $display("test continuous done");
        // request and calibrate rising together
        bus(1'b1, `ADCS_REG_IRQ_MASK, 32'h2, 4'h1);
        host.cal(1'b1);
        wait_pin(1'b1, n);
        chk_cyc("calibration time", CAL_LAT, n);
        m_stat[`ADCS_IRQ_CAL] = 1'b1;
        rd_chk(`ADCS_REG_IRQ_STAT);
        state_chk(7'h08);
        host.stop();
        bus(1'b1, `ADCS_REG_IRQ_STAT, 32'h2, 4'h1);
        // calibrate pulse during a held conversion
        host.start(2'h2, 1'b0, 1'b1);
        host.cal(1'b0);
        wait_pin(1'b1, n);
        chk_cyc("calibration from conversion", CAL_LAT, n);
        m_stat[`ADCS_IRQ_CAL] = 1'b1;
        host.stop();
        rd_chk(`ADCS_REG_IRQ_STAT);
        bus(1'b1, `ADCS_REG_IRQ_STAT, 32'h2, 4'h1);
        $display("test calibration done");
        // sleep pin, then full restart
        sleep_pin <= 1'b1;
        repeat (4) @(posedge clk);
        state_chk(7'h40);
        sleep_pin <= 1'b0;
        n = cyc;
        wait_idle(n, 0);
        rd_chk(`ADCS_REG_IRQ_STAT);
        $display("test sleep done");
        // software sleep with the crystal path, so the oscillator wait is walked as well
        bus(1'b1, `ADCS_REG_CTRL, 32'h2, 4'h1);
        state_chk(7'h40);
        rd_chk(`ADCS_REG_CTRL);
        bus(1'b1, `ADCS_REG_CTRL, 32'h0, 4'h1);
        n = cyc;
        wait_idle(n, OSC);
        rd_chk(`ADCS_REG_IRQ_STAT);
        $display("test software sleep done");
        tally_and_finish();
    end
endmodule
